// file: rtl/power_clock_pkg.sv
`default_nettype none
package power_clock_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_PMC  = 8'h6B;
  localparam logic [7:0] ADDR_PM2  = 8'h6C;
  localparam logic [7:0] PMC_RESET = 8'h00;
  localparam logic [7:0] PM2_RESET = 8'h00;
  localparam logic [7:0] PMC_WMASK = 8'hEF;

  // Power-mode register field positions
  localparam int PMC_DEV_RESET = 7;
  localparam int PMC_SLEEP     = 6;
  localparam int PMC_CYCLE     = 5;
  localparam int PMC_TEMP_OFF  = 3;

  // Standby register field positions
  localparam int PM2_WAKE_LSB  = 6;
  localparam int PM2_ACCEL_LSB = 3;
  localparam int PM2_GYRO_LSB  = 0;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int RESET_HOLD_NS     = 100;
  localparam int RESET_HOLD_CYC    =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_ON_NS        = 1000;
  localparam int WAKE_ON_CYC       =
    (WAKE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PERIOD_US_0  = 800000;
  localparam int WAKE_PERIOD_US_1  = 200000;
  localparam int WAKE_PERIOD_US_2  = 50000;
  localparam int WAKE_PERIOD_US_3  = 25000;
  localparam int WAKE_CYC_0 = WAKE_PERIOD_US_0 / CLK_PERIOD_NS * 1000;
  localparam int WAKE_CYC_1 = WAKE_PERIOD_US_1 / CLK_PERIOD_NS * 1000;
  localparam int WAKE_CYC_2 = WAKE_PERIOD_US_2 / CLK_PERIOD_NS * 1000;
  localparam int WAKE_CYC_3 = WAKE_PERIOD_US_3 / CLK_PERIOD_NS * 1000;
  localparam int WAKE_W     = 27;
  localparam int HOLD_W     = 8;

  // ==========================================================
  // Encodings
  typedef enum logic [2:0] {
    CS_OSC     = 3'h0,
    CS_GYRO_X  = 3'h1,
    CS_GYRO_Y  = 3'h2,
    CS_GYRO_Z  = 3'h3,
    CS_EXT_32K = 3'h4,
    CS_EXT_19M = 3'h5,
    CS_RSVD    = 3'h6,
    CS_STOP    = 3'h7
  } clk_src_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'h0,
    ST_SLEEP = 3'h1,
    ST_DOZE  = 3'h2,
    ST_WAKE  = 3'h3,
    ST_HALT  = 3'h4
  } mode_t;

endpackage
`default_nettype wire

// file: rtl/reset_hold_counter.sv
`default_nettype none
module reset_hold_counter
  import power_clock_pkg::*;
#(
  parameter int HOLD = RESET_HOLD_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  output var  logic busy_out,
  output var  logic done_out
);

  typedef struct packed {
    logic [HOLD_W-1:0] cnt;
    logic              busy;
    logic              done;
  } hold_state_t;

  hold_state_t st;
  hold_state_t next_st;

  // ==========================================================
  // Holds busy for HOLD cycles, then one done pulse
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      if (st.cnt == HOLD_W'(HOLD - 1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.cnt  = '0;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end else if (start_in) begin
      next_st.busy = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out = st.busy;
  assign done_out = st.done;

endmodule
`default_nettype wire

// file: rtl/wake_interval_timer.sv
`default_nettype none
module wake_interval_timer
  import power_clock_pkg::*;
#(
  parameter int W = WAKE_W
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         clr_in,
  input  wire logic [W-1:0] period_in,
  output var  logic         tick_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  // ==========================================================
  // Free count, restarted by clear; tick on the last count
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (clr_in) begin
      next_st.cnt = '0;
    end else if (st.cnt >= period_in - 1'b1) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule
`default_nettype wire

// file: rtl/power_mode_clock_select.sv
// How it works
// - Reset bit restores all registers to defaults
// - Reset bit self-clears after reset completes
// - Sleep bit enters low-power sleep mode
// - Cycle without sleep: doze/wake at wake rate
// - Temperature-disable bit powers temperature sensor off
// - Clock field selects oscillator or PLL reference
// - Value 7 stops clock, holds timing reset
// - Internal oscillator selected after power-up
// - Oscillator/external clock allows gyros all off
// - Accel-only mode wakes only the accelerometer
// - Wake-rate field: 1.25, 5, 20, 40 Hz
// - Six bits put single axes in standby
// - Standby of reference gyro falls back oscillator
`default_nettype none
module power_mode_clock_select
  import power_clock_pkg::*;
#(
  parameter logic [WAKE_W-1:0] WAKE_CYC_R0 = WAKE_W'(WAKE_CYC_0),
  parameter logic [WAKE_W-1:0] WAKE_CYC_R1 = WAKE_W'(WAKE_CYC_1),
  parameter logic [WAKE_W-1:0] WAKE_CYC_R2 = WAKE_W'(WAKE_CYC_2),
  parameter logic [WAKE_W-1:0] WAKE_CYC_R3 = WAKE_W'(WAKE_CYC_3)
) (
  input  wire logic       CLK_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  output var  logic [7:0] REG_RDATA_OUT,
  output var  logic       DEVICE_RESET_OUT,
  output var  logic       SLEEP_OUT,
  output var  logic [2:0] ACCEL_POWER_OUT,
  output var  logic [2:0] GYRO_POWER_OUT,
  output var  logic       TEMP_POWER_OUT,
  output var  logic [2:0] CLOCK_SOURCE_OUT,
  output var  logic       CLOCK_STOP_OUT,
  output var  logic       TIMING_RESET_OUT,
  output var  logic       SAMPLE_PULSE_OUT,
  output var  logic       ACCEL_ONLY_OUT
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] pmc;
    logic [7:0] pm2;
    mode_t      mode;
    logic       dev_rst;
    logic       sleep;
    logic [2:0] accel_pwr;
    logic [2:0] gyro_pwr;
    logic       temp_pwr;
    clk_src_t   clk_src;
    logic       clk_stop;
    logic       tgen_rst;
    logic       sample;
    logic       accel_only;
  } pm_state_t;

  pm_state_t st;
  pm_state_t next_st;

  logic              seq_start;
  logic              seq_busy;
  logic              seq_done;
  logic              timer_clr;
  logic              wake_tick;
  logic [WAKE_W-1:0] wake_period;
  logic [WAKE_W-1:0] doze_period;

  // Field views of the stored registers
  logic       f_sleep;
  logic       f_cycle;
  logic       f_temp_off;
  clk_src_t   f_clk;
  logic [1:0] f_wake;
  logic [2:0] f_accel_stby;
  logic [2:0] f_gyro_stby;
  logic       active;

  assign f_sleep      = st.pmc[PMC_SLEEP];
  assign f_cycle      = st.pmc[PMC_CYCLE];
  assign f_temp_off   = st.pmc[PMC_TEMP_OFF];
  assign f_clk        = clk_src_t'(st.pmc[2:0]);
  assign f_wake       = st.pm2[PM2_WAKE_LSB +: 2];
  assign f_accel_stby = st.pm2[PM2_ACCEL_LSB +: 3];
  assign f_gyro_stby  = st.pm2[PM2_GYRO_LSB +: 3];
  assign active       = (st.mode == ST_RUN) || (st.mode == ST_WAKE);

  // ==========================================================
  // Full register reset sequence
  // A reset request is taken only when none is running, so a
  // second request during the hold cannot stretch it.
  assign seq_start = REG_WR_IN && (REG_ADDR_IN == ADDR_PMC)
                     && REG_WDATA_IN[PMC_DEV_RESET]
                     && !st.pmc[PMC_DEV_RESET];

  reset_hold_counter #(
    .HOLD (RESET_HOLD_CYC)
  ) u_hold (
    .clk_in   (CLK_IN),
    .rst_in   (SYS_RST_IN),
    .start_in (seq_start),
    .busy_out (seq_busy),
    .done_out (seq_done)
  );

  // ==========================================================
  // Wake interval selection
  always_comb begin
    case (f_wake)
      2'h0:    doze_period = WAKE_CYC_R0;
      2'h1:    doze_period = WAKE_CYC_R1;
      2'h2:    doze_period = WAKE_CYC_R2;
      2'h3:    doze_period = WAKE_CYC_R3;
      default: doze_period = WAKE_CYC_R0;
    endcase
  end

  // Wake window is short and fixed; doze spans the whole selected period
  assign wake_period = (st.mode == ST_WAKE)
                       ? WAKE_W'(WAKE_ON_CYC) : doze_period;

  // Restart the timer whenever the mode changes or cycling stops
  assign timer_clr = (next_st.mode != st.mode)
                     || !((st.mode == ST_DOZE) || (st.mode == ST_WAKE));

  wake_interval_timer #(
    .W (WAKE_W)
  ) u_wake (
    .clk_in    (CLK_IN),
    .rst_in    (SYS_RST_IN),
    .clr_in    (timer_clr),
    .period_in (wake_period),
    .tick_out  (wake_tick)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_st       = st;
    next_st.rdata = 8'h00;

    // Register writes; ignored while a full reset is held
    if (REG_WR_IN && !st.pmc[PMC_DEV_RESET]) begin
      case (REG_ADDR_IN)
        ADDR_PMC: next_st.pmc = REG_WDATA_IN & PMC_WMASK;
        ADDR_PM2: next_st.pm2 = REG_WDATA_IN;
        default:  next_st.pmc = st.pmc;
      endcase
    end

    // End of the hold: defaults back, request bit drops
    if (seq_done) begin
      next_st.pmc = PMC_RESET;
      next_st.pm2 = PM2_RESET;
    end

    // A gyro reference whose axis sleeps cannot drive the PLL
    if ((next_st.pmc[2:0] >= 3'(CS_GYRO_X))
        && (next_st.pmc[2:0] <= 3'(CS_GYRO_Z))
        && next_st.pm2[3'h3 - next_st.pmc[2:0]]) begin
      next_st.pmc[2:0] = 3'(CS_OSC);
    end

    // Reads are served in every mode, sleep included
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        ADDR_PMC: next_st.rdata = st.pmc & PMC_WMASK;
        ADDR_PM2: next_st.rdata = st.pm2;
        default:  next_st.rdata = 8'h00;
      endcase
    end

    // Power mode sequencing
    case (st.mode)
      ST_RUN, ST_SLEEP, ST_HALT: begin
        next_st.mode = (f_cycle && !f_sleep) ? ST_DOZE : ST_RUN;
      end
      ST_DOZE: begin
        next_st.mode = wake_tick ? ST_WAKE : ST_DOZE;
      end
      ST_WAKE: begin
        next_st.mode = wake_tick ? ST_DOZE : ST_WAKE;
      end
      default: begin
        next_st.mode = ST_RUN;
      end
    endcase
    if (!f_cycle && (st.mode != ST_SLEEP)) begin
      next_st.mode = ST_RUN;
    end
    if (f_sleep) begin
      next_st.mode = ST_SLEEP;
    end
    if (f_clk == CS_STOP) begin
      next_st.mode = ST_HALT;
    end

    // Outputs, one cycle behind the state they reflect
    next_st.dev_rst   = seq_busy;
    next_st.sleep     = (st.mode == ST_SLEEP);
    next_st.sample    = (st.mode == ST_DOZE) && wake_tick;
    next_st.accel_pwr = active ? ~f_accel_stby : 3'h0;
    next_st.temp_pwr  = active && !f_temp_off;
    // Gyros stay off across the wake window in accel-only
    // mode; oscillator or external clocks keep running without
    // them, which is what makes this mode legal.
    next_st.gyro_pwr  = (st.mode == ST_RUN)
                        ? ~f_gyro_stby : 3'h0;
    if (st.mode == ST_WAKE && !(&f_gyro_stby)) begin
      next_st.gyro_pwr = ~f_gyro_stby;
    end
    next_st.accel_only = f_cycle && !f_sleep && f_temp_off
                         && (&f_gyro_stby);

    // Reserved code keeps the oscillator running
    case (f_clk)
      CS_RSVD: next_st.clk_src = CS_OSC;
      default: next_st.clk_src = f_clk;
    endcase
    next_st.clk_stop = (f_clk == CS_STOP);
    next_st.tgen_rst = (f_clk == CS_STOP);
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st          <= '0;
      st.pmc      <= PMC_RESET;
      st.pm2      <= PM2_RESET;
      st.mode     <= ST_RUN;
      st.clk_src  <= CS_OSC;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign REG_RDATA_OUT    = st.rdata;
  assign DEVICE_RESET_OUT = st.dev_rst;
  assign SLEEP_OUT        = st.sleep;
  assign ACCEL_POWER_OUT  = st.accel_pwr;
  assign GYRO_POWER_OUT   = st.gyro_pwr;
  assign TEMP_POWER_OUT   = st.temp_pwr;
  assign CLOCK_SOURCE_OUT = st.clk_src;
  assign CLOCK_STOP_OUT   = st.clk_stop;
  assign TIMING_RESET_OUT = st.tgen_rst;
  assign SAMPLE_PULSE_OUT = st.sample;
  assign ACCEL_ONLY_OUT   = st.accel_only;

  // ==========================================================
  // Checks
  localparam int RST_BOUND = 16;

  logic gyro_ref_stby;
  assign gyro_ref_stby = (f_clk == CS_GYRO_X && f_gyro_stby[2])
                      || (f_clk == CS_GYRO_Y && f_gyro_stby[1])
                      || (f_clk == CS_GYRO_Z && f_gyro_stby[0]);

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  // Defaults return when the request bit drops
  a_full_reset_defaults: assert property (
    $fell(st.pmc[PMC_DEV_RESET])
      |-> (st.pmc == PMC_RESET) && (st.pm2 == PM2_RESET)
  ) else $error("registers not at defaults after full reset");

  // Request bit must clear within a bounded hold
  a_reset_self_clear: assert property (
    $rose(st.pmc[PMC_DEV_RESET])
      |-> ##[1:RST_BOUND] !st.pmc[PMC_DEV_RESET]
  ) else $error("full reset bit did not clear itself");

  // Sleep mode shows up on the pins one cycle later
  a_sleep_outputs: assert property (
    (st.mode == ST_SLEEP)
      |=> SLEEP_OUT && (ACCEL_POWER_OUT == 3'h0)
          && (GYRO_POWER_OUT == 3'h0) && !TEMP_POWER_OUT
  ) else $error("sleep mode left sensors powered");

  // Timer tick during doze moves to the wake window
  a_doze_to_wake: assert property (
    (st.mode == ST_DOZE) && wake_tick && f_cycle && !f_sleep
      && (f_clk != CS_STOP)
      |=> (st.mode == ST_WAKE) ##1 !SAMPLE_PULSE_OUT
  ) else $error("cycle mode did not wake on tick");

  // Temperature disable keeps the sensor off when active
  a_temp_off: assert property (
    f_temp_off |=> !TEMP_POWER_OUT
  ) else $error("temperature sensor powered while disabled");

  // Valid clock codes reach the clock select pins
  a_clock_select: assert property (
    (st.pmc[2:0] <= 3'h5)
      |=> (CLOCK_SOURCE_OUT == $past(st.pmc[2:0]))
  ) else $error("clock source output does not follow field");

  // Stop code halts the clock and the timing generator
  a_clock_stop: assert property (
    (f_clk == CS_STOP)
      |=> CLOCK_STOP_OUT && TIMING_RESET_OUT && (st.mode == ST_HALT)
  ) else $error("stop code did not halt timing");

  // Accel-only doze keeps the gyros and the temperature sensor unpowered
  a_accel_only_doze: assert property (
    ACCEL_ONLY_OUT && (st.mode == ST_DOZE) && $stable(st.pmc)
      |=> (GYRO_POWER_OUT == 3'h0) && !TEMP_POWER_OUT
  ) else $error("accel-only doze left sensors powered");

  // A sleeping gyro axis is never the stored clock reference
  a_gyro_fallback: assert property (
    !gyro_ref_stby
  ) else $error("clock reference gyro axis is in standby");

  // Reserved power-mode bit reads as zero
  a_reserved_zero: assert property (
    REG_RD_IN && (REG_ADDR_IN == ADDR_PMC) |=> !REG_RDATA_OUT[4]
  ) else $error("reserved bit 4 read back as one");

  // Standby register reads back in every mode
  a_standby_readback: assert property (
    REG_RD_IN && (REG_ADDR_IN == ADDR_PM2)
      |=> (REG_RDATA_OUT == $past(st.pm2))
  ) else $error("standby register read back wrong");

  // Running accelerometer axes follow their standby bits
  a_accel_standby: assert property (
    (st.mode == ST_RUN)
      |=> (ACCEL_POWER_OUT == ~$past(f_accel_stby))
  ) else $error("accelerometer power does not follow standby");

  // A write during the hold must not land in the standby register
  a_hold_write_ignored: assert property (
    REG_WR_IN && st.pmc[PMC_DEV_RESET] && !seq_done
      |=> (st.pm2 == $past(st.pm2))
  ) else $error("register write landed during full reset");

endmodule
`default_nettype wire

// file: tb/power_mode_clock_select_test.sv
`default_nettype none
module power_mode_clock_select_test
  import power_clock_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals and design
  // Short doze periods keep the cycle-mode run brief
  localparam int PER [4] = '{40, 30, 20, 10};

  logic       clk   = 1'b0;
  logic       rst   = 1'b1;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic [7:0] rdata;
  logic       dev_rst;
  logic       sleep;
  logic       clk_stop;
  logic       tim_rst;
  logic       pulse;
  logic       acc_only;
  logic       temp_pwr;
  logic [2:0] acc_pwr;
  logic [2:0] gyr_pwr;
  logic [2:0] clk_src;
  int         n_errors        = 0;
  int         samples_checked = 0;

  power_mode_clock_select #(
    .WAKE_CYC_R0 (WAKE_W'(PER[0])),
    .WAKE_CYC_R1 (WAKE_W'(PER[1])),
    .WAKE_CYC_R2 (WAKE_W'(PER[2])),
    .WAKE_CYC_R3 (WAKE_W'(PER[3]))
  ) dut (
    .CLK_IN           (clk),
    .SYS_RST_IN       (rst),
    .REG_ADDR_IN      (addr),
    .REG_WDATA_IN     (wdata),
    .REG_WR_IN        (wr),
    .REG_RD_IN        (rd),
    .REG_RDATA_OUT    (rdata),
    .DEVICE_RESET_OUT (dev_rst),
    .SLEEP_OUT        (sleep),
    .ACCEL_POWER_OUT  (acc_pwr),
    .GYRO_POWER_OUT   (gyr_pwr),
    .TEMP_POWER_OUT   (temp_pwr),
    .CLOCK_SOURCE_OUT (clk_src),
    .CLOCK_STOP_OUT   (clk_stop),
    .TIMING_RESET_OUT (tim_rst),
    .SAMPLE_PULSE_OUT (pulse),
    .ACCEL_ONLY_OUT   (acc_only)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Sample 1 ns after the edge so that its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check(what, d, e);
  endtask

  // Bounded so a missing pulse cannot hang the run
  task automatic next_pulse(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (pulse !== 1'b1 && n < 400);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    tick(3);
    check("accel power", acc_pwr, 3'h7);
    check("gyro power", gyr_pwr, 3'h7);
    check("temp power", temp_pwr, 1'b1);
    check("clock source", clk_src, CS_OSC);
    expect_reg("pmc reset", ADDR_PMC, PMC_RESET);
    tick(1);
    check("rdata after one cycle", rdata, 8'h00);
    expect_reg("pm2 reset", ADDR_PM2, PM2_RESET);
    wr_reg(8'h6D, 8'h55);
    expect_reg("unmapped", 8'h6D, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_clock();
    for (int c = 0; c < 8; c++) begin
      wr_reg(ADDR_PMC, 8'(c));
      tick(4);
      check("clock source", clk_src, (c == 6) ? 3'h0 : 3'(c));
      check("clock stop", clk_stop, c == 7);
      check("timing reset", tim_rst, c == 7);
      expect_reg("clock field", ADDR_PMC, 8'(c));
    end
    wr_reg(ADDR_PMC, 8'h1D);
    tick(4);
    expect_reg("reserved bit", ADDR_PMC, 8'h0D);
    check("temp off", temp_pwr, 1'b0);
    check("ext clock", clk_src, CS_EXT_19M);
    $display("test clock done");
  endtask

  task automatic t_standby();
    wr_reg(ADDR_PMC, 8'h00);
    wr_reg(ADDR_PM2, 8'h2A);
    tick(4);
    check("accel standby", acc_pwr, 3'h2);
    check("gyro standby", gyr_pwr, 3'h5);
    check("not accel only", acc_only, 1'b0);
    expect_reg("standby reg", ADDR_PM2, 8'h2A);
    $display("test standby done");
  endtask

  // Only the axis that is the reference may force the fallback
  task automatic t_fallback();
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_PM2, 8'h00);
      wr_reg(ADDR_PMC, 8'(i + 1));
      wr_reg(ADDR_PM2, ~(8'h04 >> i) & 8'h07);
      expect_reg("other axis", ADDR_PMC, 8'(i + 1));
      wr_reg(ADDR_PM2, 8'h04 >> i);
      tick(3);
      expect_reg("fallback", ADDR_PMC, 8'h00);
      check("fallback source", clk_src, CS_OSC);
      wr_reg(ADDR_PMC, 8'(i + 1));
      expect_reg("refused code", ADDR_PMC, 8'h00);
    end
    $display("test fallback done");
  endtask

  task automatic t_sleep();
    int cnt;
    cnt = 0;
    wr_reg(ADDR_PM2, 8'h00);
    wr_reg(ADDR_PMC, 8'h60);
    tick(4);
    check("sleep", sleep, 1'b1);
    check("sleep accel", acc_pwr, 3'h0);
    wr_reg(ADDR_PM2, 8'h15);
    expect_reg("sleep access", ADDR_PM2, 8'h15);
    repeat (150) begin
      tick(1);
      if (pulse === 1'b1) cnt++;
    end
    check("sleep no samples", cnt, 0);
    wr_reg(ADDR_PMC, 8'h00);
    tick(4);
    check("awake", sleep, 1'b0);
    $display("test sleep done");
  endtask

  // Wide tolerance still tells the four rates apart
  task automatic t_cycle();
    int n;
    int e;
    for (int r = 0; r < 4; r++) begin
      e = PER[r] + WAKE_ON_CYC;
      wr_reg(ADDR_PM2, 8'(r << 6) | 8'h07);
      wr_reg(ADDR_PMC, 8'h2C);
      tick(4);
      check("accel only", acc_only, 1'b1);
      check("ext clock kept", clk_src, CS_EXT_32K);
      next_pulse(n);
      // Power outputs follow the wake state one cycle after the pulse
      tick(1);
      check("pulse width", pulse, 1'b0);
      check("sample accel", acc_pwr, 3'h7);
      check("sample gyro", gyr_pwr, 3'h0);
      check("sample temp", temp_pwr, 1'b0);
      next_pulse(n);
      check("wake interval", (n >= e - 2) && (n <= e + 2), 1'b1);
    end
    $display("test cycle done");
  endtask

  task automatic t_devreset();
    int n;
    wr_reg(ADDR_PM2, 8'h3F);
    wr_reg(ADDR_PMC, 8'h0D);
    wr_reg(ADDR_PMC, 8'h8D);
    expect_reg("reset bit held", ADDR_PMC, 8'h8D);
    wr_reg(ADDR_PM2, 8'hC0);
    expect_reg("hold write ignored", ADDR_PM2, 8'h3F);
    n = 0;
    while (dev_rst !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("reset signalled", dev_rst, 1'b1);
    n = 0;
    while (dev_rst === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check("reset ended", dev_rst, 1'b0);
    tick(4);
    expect_reg("pmc default", ADDR_PMC, PMC_RESET);
    expect_reg("pm2 default", ADDR_PM2, PM2_RESET);
    check("source default", clk_src, CS_OSC);
    check("temp default", temp_pwr, 1'b1);
    $display("test device reset done");
  endtask

  // ==========================================================
  // Verdict, clock, reset, watchdog
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clock();
    t_standby();
    t_fallback();
    t_sleep();
    t_cycle();
    t_devreset();
    complete_run();
  end

  // Whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
